// ---- include/scan_tap_regs.svh ----
`ifndef SCAN_TAP_REGS_SVH
`define SCAN_TAP_REGS_SVH

// Instruction register geometry and defaults
`define TAP_IR_W 3
`define TAP_IR_CAPTURE 3'h1
`define TAP_IR_CAPTURE_LSBS 2'h1

// Instruction codes; only the all-zero code is fixed by the device
`define TAP_INS_EXTEST 3'h0
`define TAP_INS_IDCODE 3'h1
`define TAP_INS_SAMPLE_Z 3'h2
`define TAP_INS_SAMPLE 3'h4
`define TAP_INS_BYPASS 3'h7

// Identification register geometry
`define TAP_ID_W 32

// Rising edges with mode select high that force the reset state
`define TAP_RESET_EDGES 5

// Bypass stage capture value
`define TAP_BYPASS_CAPTURE 1'h0

`endif

// ---- include/scan_tap_pkg.sv ----
package scan_tap_pkg;
`include "scan_tap_regs.svh"

    // Sixteen controller states
    typedef enum logic [3:0] {
        st_tlr, st_rti,
        st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
        st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
    } tap_state_t;

    typedef logic [`TAP_IR_W-1:0] instr_t;

    // Data register placed on the chain
    typedef enum logic [1:0] {
        dr_bypass, dr_ident, dr_boundary
    } dr_sel_t;

endpackage

// ---- core/sync_2ff.sv ----
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level from the other domain, and its resynchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// ---- core/sram_boundary_scan_tap.sv ----
`timescale 1ns/1ps
`include "scan_tap_regs.svh"
module sram_boundary_scan_tap #(
    parameter int BSR_LEN = 8,
    parameter logic [`TAP_ID_W-1:0] ID_CODE = 32'h0A5C_3E01 // Arbitrary value, bit 0 set
) (
    // Memory clock domain and power-up reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Test port pins, with drive indication for the inputs
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_drv,
    input wire logic tdi,
    input wire logic tdi_drv,
    output logic tdo,
    output logic tdo_oe,
    // Memory pin levels for boundary capture
    input wire logic [BSR_LEN-1:0] pin_levels,
    // Memory output release request, memory clock domain
    output logic mem_hiz
);
    import scan_tap_pkg::*;

    // Controller transition, one mode select bit per rising edge
    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        tap_state_t n;
        n = s;
        unique case (s)
            st_tlr: n = m ? st_tlr : st_rti;
            st_rti: n = m ? st_sel_dr : st_rti;
            st_sel_dr: n = m ? st_sel_ir : st_cap_dr;
            st_cap_dr: n = m ? st_exit1_dr : st_shift_dr;
            st_shift_dr: n = m ? st_exit1_dr : st_shift_dr;
            st_exit1_dr: n = m ? st_upd_dr : st_pause_dr;
            st_pause_dr: n = m ? st_exit2_dr : st_pause_dr;
            st_exit2_dr: n = m ? st_upd_dr : st_shift_dr;
            st_upd_dr: n = m ? st_sel_dr : st_rti;
            st_sel_ir: n = m ? st_tlr : st_cap_ir;
            st_cap_ir: n = m ? st_exit1_ir : st_shift_ir;
            st_shift_ir: n = m ? st_exit1_ir : st_shift_ir;
            st_exit1_ir: n = m ? st_upd_ir : st_pause_ir;
            st_pause_ir: n = m ? st_exit2_ir : st_pause_ir;
            st_exit2_ir: n = m ? st_upd_ir : st_shift_ir;
            st_upd_ir: n = m ? st_sel_ir : st_rti;
        endcase
        return n;
    endfunction

    logic trst_n;
    logic [BSR_LEN-1:0] pins_tck;
    tap_state_t state_q;
    tap_state_t state_d;
    instr_t ir_sh_q;
    instr_t ir_q;
    logic [`TAP_ID_W-1:0] id_sh_q;
    logic [BSR_LEN-1:0] bsr_q;
    logic byp_q;
    logic hiz_tck_q;
    logic tdo_q;
    logic tdo_oe_q;

    // Power-up reset, released in step with the test clock; no other reset path
    sync_2ff #(
        .W(1)
    ) u_trst_sync (
        .clk(tck),
        .rst_n(rst_n),
        .d(1'b1),
        .q(trst_n)
    );

    // Memory pins come from another clock; capture can still catch them mid-change
    sync_2ff #(
        .W(BSR_LEN)
    ) u_pin_sync (
        .clk(tck),
        .rst_n(rst_n),
        .d(pin_levels),
        .q(pins_tck)
    );

    // Release request into the memory domain as a level
    sync_2ff #(
        .W(1)
    ) u_hiz_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(hiz_tck_q),
        .q(mem_hiz)
    );

    // Undriven inputs read as one, as a pull-up would give
    wire tms_eff = tms_drv ? tms : 1'b1;
    wire tdi_eff = tdi_drv ? tdi : 1'b1;

    // State decodes
    wire in_tlr = (state_q == st_tlr);
    wire cap_ir = (state_q == st_cap_ir);
    wire shift_ir = (state_q == st_shift_ir);
    wire upd_ir = (state_q == st_upd_ir);
    wire cap_dr = (state_q == st_cap_dr);
    wire shift_dr = (state_q == st_shift_dr);
    wire shift_any = shift_ir | shift_dr;

    // Data register choice from the held instruction; unknown codes fall to bypass
    wire ins_ident = (ir_q == `TAP_INS_IDCODE);
    wire ins_bound = (ir_q == `TAP_INS_SAMPLE) | (ir_q == `TAP_INS_EXTEST) | (ir_q == `TAP_INS_SAMPLE_Z);
    wire dr_sel_t dr_sel = ins_ident ? dr_ident : (ins_bound ? dr_boundary : dr_bypass);
    wire hiz_d = (ir_q == `TAP_INS_EXTEST) | (ir_q == `TAP_INS_SAMPLE_Z);

    // Chain output: one register at a time, picked by state and instruction
    wire dr_out = (dr_sel == dr_ident) ? id_sh_q[0] :
                  (dr_sel == dr_boundary) ? bsr_q[0] : byp_q;
    wire chain_out = shift_ir ? ir_sh_q[0] : dr_out;

    assign state_d = tap_next(state_q, tms_eff);

    // Controller state, advanced on rising test clock only
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            state_q <= st_tlr;
        end else begin
            state_q <= state_d;
        end
    end

    // Instruction shifter; touched only while on the chain
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_sh_q <= `TAP_IR_CAPTURE;
        end else if (cap_ir) begin
            ir_sh_q <= `TAP_IR_CAPTURE;
        end else if (shift_ir) begin
            ir_sh_q <= {tdi_eff, ir_sh_q[`TAP_IR_W-1:1]};
        end
    end

    // Held instruction: identification in reset, new code only at update
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_q <= `TAP_INS_IDCODE;
        end else if (in_tlr) begin
            ir_q <= `TAP_INS_IDCODE;
        end else if (upd_ir) begin
            ir_q <= ir_sh_q;
        end
    end

    // Identification register, least significant bit leaves first
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            id_sh_q <= '0;
        end else if (cap_dr && dr_sel == dr_ident) begin
            id_sh_q <= ID_CODE;
        end else if (shift_dr && dr_sel == dr_ident) begin
            id_sh_q <= {tdi_eff, id_sh_q[`TAP_ID_W-1:1]};
        end
    end

    // Boundary register, loaded from the resynchronised pins
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            bsr_q <= '0;
        end else if (cap_dr && dr_sel == dr_boundary) begin
            bsr_q <= pins_tck;
        end else if (shift_dr && dr_sel == dr_boundary) begin
            bsr_q <= {tdi_eff, bsr_q[BSR_LEN-1:1]};
        end
    end

    // Single bypass stage
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            byp_q <= `TAP_BYPASS_CAPTURE;
        end else if (cap_dr && dr_sel == dr_bypass) begin
            byp_q <= `TAP_BYPASS_CAPTURE;
        end else if (shift_dr && dr_sel == dr_bypass) begin
            byp_q <= tdi_eff;
        end
    end

    // Output release follows the held instruction; idle after reset keeps memory normal
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            hiz_tck_q <= 1'b0;
        end else begin
            hiz_tck_q <= hiz_d;
        end
    end

    // Data out on the falling edge, a half cycle of hold for the next device
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= shift_any ? chain_out : tdo_q;
            tdo_oe_q <= shift_any;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // Helper: run of rising edges with mode select high, saturating
    logic [2:0] ones_cnt_q;
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ones_cnt_q <= 3'h0;
        end else if (!tms_eff) begin
            ones_cnt_q <= 3'h0;
        end else if (ones_cnt_q != 3'h7) begin
            ones_cnt_q <= ones_cnt_q + 3'h1;
        end
    end

    wire ir_sh_busy = cap_ir | shift_ir;

    // Five high samples always land in reset, from any state
    tlr_after_five_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        (ones_cnt_q >= 3'h5) |-> in_tlr)
        else $error("controller not in reset after five high mode samples");

    // Reset state forces identification instruction
    ir_default_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        in_tlr |=> (ir_q == `TAP_INS_IDCODE))
        else $error("instruction not identification after reset state");

    // Capture loads the fixed low pattern
    capture_pattern_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        cap_ir |=> (ir_sh_q[1:0] == `TAP_IR_CAPTURE_LSBS))
        else $error("capture pattern missing from instruction shifter");

    // Held instruction moves only at update or reset
    ir_hold_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        (!upd_ir && !in_tlr) |=> $stable(ir_q))
        else $error("instruction changed outside update");

    // Shifter untouched while off the chain
    ir_shift_only_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        !ir_sh_busy |=> $stable(ir_sh_q))
        else $error("instruction shifter changed off the chain");

    // Bypass passes data in after exactly one stage
    bypass_delay_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        (shift_dr && dr_sel == dr_bypass) |=> (byp_q == $past(tdi_eff)))
        else $error("bypass stage did not take data in");

    // Identification capture then first bit out is bit 0
    id_capture_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        (cap_dr && dr_sel == dr_ident) |=> (id_sh_q == ID_CODE) ##0 (dr_out == ID_CODE[0]))
        else $error("identification capture wrong");

    // Enable follows shift states at the falling edge
    tdo_enable_a: assert property (
        @(negedge tck) disable iff (!trst_n)
        shift_any |=> tdo_oe_q)
        else $error("data out not driven in shift state");

    // Released outside shifting, value frozen
    tdo_release_a: assert property (
        @(negedge tck) disable iff (!trst_n)
        !shift_any |=> (!tdo_oe_q && $stable(tdo_q)))
        else $error("data out active outside shift state");

    // Transition diagram on every rising edge
    next_state_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        1'b1 |=> (state_q == tap_next($past(state_q), $past(tms_eff))))
        else $error("illegal controller transition");

    // Main scenarios
    cover_ir_load_c: cover property (@(posedge tck) disable iff (!trst_n) shift_ir ##1 !shift_ir ##[1:3] upd_ir);
    cover_id_read_c: cover property (@(posedge tck) disable iff (!trst_n)
        (cap_dr && dr_sel == dr_ident) ##1 shift_dr [*8]);
    cover_bypass_c: cover property (@(posedge tck) disable iff (!trst_n) shift_dr && dr_sel == dr_bypass);
    cover_boundary_c: cover property (@(posedge tck) disable iff (!trst_n) cap_dr && dr_sel == dr_boundary);
    cover_reset_c: cover property (@(posedge tck) disable iff (!trst_n) !in_tlr ##1 tms_eff [*5] ##1 in_tlr);

endmodule

// ---- verif/tap_host_model.sv ----
`timescale 1ns/1ps
module tap_host_model (
    // Test port, host-driven side
    output logic tck,
    output logic tms,
    output logic tms_drv,
    output logic tdi,
    output logic tdi_drv,
    // Test port, returned side
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Set before any process runs, so a call at time zero sees driven pins
    logic tms_free = 1'b0;
    logic tdi_free = 1'b0;
    // A released data out shows a flipped level so stale bits never pass
    wire tdo_pin = tdo_oe ? tdo : ~tdo;

    // Clock stands still low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        tms_drv = 1'b1;
        tdi_drv = 1'b1;
    end

    // One test clock period; a released pin toggles so only the pull-up reading can pass
    task automatic step(input logic m, input logic d, output logic o, output logic oe);
        tms_drv = ~tms_free;
        tdi_drv = ~tdi_free;
        tms = tms_free ? ~tms : m;
        tdi = tdi_free ? ~tdi : d;
        #24;
        tck = 1'b1;
        o = tdo_pin;
        oe = tdo_oe;
        #24;
        tck = 1'b0;
    endtask

    task automatic move(input logic m);
        logic o;
        logic oe;
        step(m, 1'b1, o, oe);
    endtask

    // Five or more high edges, then idle
    task automatic reset_seq();
        repeat (6) move(1'b1);
        move(1'b0);
    endtask

    // From idle: load an instruction, back to idle
    task automatic ir_load(input logic [2:0] code, output logic [2:0] cap, output logic oe_all);
        logic o;
        logic oe;
        move(1'b1);
        move(1'b1);
        move(1'b0);
        move(1'b0);
        oe_all = 1'b1;
        for (int i = 0; i < 3; i++) begin
            step(i == 2, code[i], o, oe);
            cap[i] = o;
            oe_all &= oe;
        end
        move(1'b1);
        move(1'b0);
    endtask

    // From idle: 40-bit data scan, back to idle
    task automatic dr_scan(input logic [39:0] pat, output logic [39:0] got, output logic oe_all);
        logic o;
        logic oe;
        move(1'b1);
        move(1'b0);
        move(1'b0);
        oe_all = 1'b1;
        for (int i = 0; i < 40; i++) begin
            step(i == 39, pat[i], o, oe);
            got[i] = o;
            oe_all &= oe;
        end
        move(1'b1);
        move(1'b0);
    endtask
endmodule

// ---- verif/sram_boundary_scan_tap_test.sv ----
`timescale 1ns/1ps
`include "scan_tap_regs.svh"
module sram_boundary_scan_tap_test;
    import scan_tap_pkg::*;
    localparam logic [31:0] ID_V = 32'h1234_5679; // Arbitrary value, bit 0 set
    localparam logic [39:0] PAT = 40'hC3_5A17_E9B4;
    localparam int LIMIT = 8000;
    typedef struct {instr_t ins; int len; logic [31:0] cap; logic hiz;} row_t;
    logic clk_sys, rst_n;
    // Pins driven by the partner model or by the design
    wire tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, mem_hiz;
    logic [7:0] pin_levels;
    logic [39:0] got;
    logic [2:0] cap;
    logic oe;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    row_t rows [7] = '{
        '{`TAP_INS_IDCODE, 32, ID_V, 1'b0}, '{`TAP_INS_BYPASS, 1, 32'h0, 1'b0},
        '{`TAP_INS_SAMPLE, 8, 32'hA5, 1'b0}, '{`TAP_INS_SAMPLE_Z, 8, 32'h3C, 1'b1},
        '{`TAP_INS_EXTEST, 8, 32'hC3, 1'b1}, '{3'h3, 1, 32'h0, 1'b0}, '{3'h6, 1, 32'h0, 1'b0}};

    sram_boundary_scan_tap #(.BSR_LEN(8), .ID_CODE(ID_V)) i_sram_boundary_scan_tap (
        .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi),
        .tdi_drv(tdi_drv), .tdo(tdo), .tdo_oe(tdo_oe), .pin_levels(pin_levels), .mem_hiz(mem_hiz));
    tap_host_model i_tap_host_model (
        .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv),
        .tdo(tdo), .tdo_oe(tdo_oe));

    // Memory clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    // Captured bits come first, then the scan pattern delayed by the register length
    function automatic logic [39:0] exp_scan(input logic [31:0] c, input int len, input logic [39:0] p);
        logic [39:0] e;
        for (int i = 0; i < 40; i++) e[i] = (i < len) ? c[i] : p[i - len];
        return e;
    endfunction

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic hiz_chk(input logic e);
        repeat (4) @(posedge clk_sys);
        #1;
        chk(40'(mem_hiz), 40'(e));
    endtask

    // Main sequence; the released data out must show after each row's data scan returns to idle
    initial begin
        rst_n = 1'b0;
        pin_levels = 8'h00;
        i_tap_host_model.move(1'b1);
        repeat (3) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        hiz_chk(1'b0);
        i_tap_host_model.reset_seq();
        i_tap_host_model.dr_scan(PAT, got, oe);
        chk(got, exp_scan(ID_V, 32, PAT));
        foreach (rows[r]) begin
            pin_levels = rows[r].cap[7:0];
            i_tap_host_model.ir_load(rows[r].ins, cap, oe);
            chk(40'(cap), 40'h1);
            chk(40'(oe), 40'h1);
            // Release flop follows the held instruction only on a test clock edge
            i_tap_host_model.move(1'b0);
            hiz_chk(rows[r].hiz);
            i_tap_host_model.dr_scan(PAT, got, oe);
            chk(got, exp_scan(rows[r].cap, rows[r].len, PAT));
            #1 chk(40'({oe, tdo_oe}), 40'h2);
        end
        // Shifted but not updated instruction leaves the held one in force
        i_tap_host_model.ir_load(`TAP_INS_EXTEST, cap, oe);
        i_tap_host_model.move(1'b1);
        i_tap_host_model.move(1'b1);
        i_tap_host_model.move(1'b0);
        i_tap_host_model.move(1'b0);
        for (int i = 0; i < 3; i++) i_tap_host_model.step(i == 2, 1'(`TAP_INS_IDCODE >> i), cap[0], oe);
        i_tap_host_model.move(1'b0);
        i_tap_host_model.move(1'b0);
        hiz_chk(1'b1);
        i_tap_host_model.move(1'b1);
        i_tap_host_model.move(1'b1);
        i_tap_host_model.move(1'b0);
        i_tap_host_model.move(1'b0);
        hiz_chk(1'b0);
        // Undriven data in reads as ones through bypass
        i_tap_host_model.ir_load(`TAP_INS_BYPASS, cap, oe);
        i_tap_host_model.tdi_free = 1'b1;
        i_tap_host_model.dr_scan(PAT, got, oe);
        i_tap_host_model.tdi_free = 1'b0;
        chk(got, exp_scan(32'h0, 1, {40{1'b1}}));
        // Undriven mode select for five edges forces logic reset
        i_tap_host_model.tms_free = 1'b1;
        repeat (5) i_tap_host_model.move(1'b0);
        i_tap_host_model.tms_free = 1'b0;
        i_tap_host_model.move(1'b0);
        i_tap_host_model.dr_scan(PAT, got, oe);
        chk(got, exp_scan(ID_V, 32, PAT));
        // Second power-up reset without any mode select sequence
        i_tap_host_model.ir_load(`TAP_INS_BYPASS, cap, oe);
        @(posedge clk_sys);
        #1 rst_n = 1'b0;
        i_tap_host_model.move(1'b0);
        @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) i_tap_host_model.move(1'b0);
        i_tap_host_model.dr_scan(PAT, got, oe);
        chk(got, exp_scan(ID_V, 32, PAT));
        stop_test();
    end
endmodule
